// ===== common/cdou_regs.vh
// Register map, field positions, action codes, reset values and bus responses for the compare/dead time unit
`ifndef CDOU_REGS_VH
`define CDOU_REGS_VH
// Byte offsets on the AXI4-Lite bus
`define CDOU_OFF_CTRL     8'h00
`define CDOU_OFF_ACTION   8'h04
`define CDOU_OFF_FLAGS    8'h08
`define CDOU_OFF_IRQ_EN   8'h0c
`define CDOU_OFF_FORCE    8'h10
`define CDOU_OFF_DEADTIME 8'h14
`define CDOU_OFF_CMP_A    8'h18
`define CDOU_OFF_CMP_B    8'h1c
`define CDOU_OFF_CMP_C    8'h20
`define CDOU_OFF_CMP_D    8'h24
// Control register fields
`define CDOU_CTRL_WMS_LO  0
`define CDOU_CTRL_WMS_HI  1
`define CDOU_CTRL_PWM_A   2
`define CDOU_CTRL_PWM_B   3
`define CDOU_CTRL_PWM_D   4
`define CDOU_CTRL_INV     5
`define CDOU_CTRL_DTPS_LO 6
`define CDOU_CTRL_DTPS_HI 7
// Dead time register fields
`define CDOU_DT_RISE_LO   4
`define CDOU_DT_RISE_HI   7
`define CDOU_DT_FALL_LO   0
`define CDOU_DT_FALL_HI   3
// Action codes and modes
`define CDOU_ACT_NONE     2'h0
`define CDOU_ACT_COMP     2'h1
`define CDOU_ACT_CLEAR    2'h2
`define CDOU_ACT_SET      2'h3
`define CDOU_WMS_FAST     2'h0
// Reset values
`define CDOU_RST_CTRL     8'h00
`define CDOU_RST_ACTION   6'h00
`define CDOU_RST_DT       8'h00
`define CDOU_RST_CMP      10'h000
// Bus responses
`define CDOU_RESP_OKAY    2'h0
`define CDOU_RESP_SLVERR  2'h2
`endif

// ===== rtl/cdou_top.v
// Output compare, waveform, dead time and pin override logic with AXI4-Lite registers
// Behaviour
// - Compare counter with registers A, B, D, flag next tick
// - Set flag with enable requests its interrupt
// - Flag clears on service or written one
// - PWM modes buffer compare writes until top/bottom
// - Compare reads return most recently written value
// - Force strobe acts like match in normal mode only, no flag
// - Counter write blocks matches on next tick
// - Action bits unbuffered, effective next match
// - Three dead time generators, separate rise/fall delays
// - Complementary pair with dead time for PWM 01
// - Dead time prescaler divides by 1,2,4,8
// - Four-bit down counter holds rising transition
// - Rising edge loads rise field, falling fall
// - Zero dead time still lags one tick
// - Inversion makes both outputs high in gap
// - Normal mode output follows with one-tick delay
// - PWM other than 01 behaves like normal
// - Reset clears outputs; mode change keeps state
// - Active action overrides true port, pair mode comp port; direction stays
// - Action zero does nothing at a match
// - Normal mode action 1 toggles on match
// - Fast PWM: 2 normal, 3 inverted, 1 pair
`include "cdou_regs.vh"
module cdou_top #(
  parameter CW = 10
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          timer_tick,
  input  wire [CW-1:0] timer_count_value,
  input  wire          count_at_top,
  input  wire          count_at_bottom,
  input  wire          count_down,
  input  wire          count_write,
  input  wire [2:0]    irq_service,
  input  wire [2:0]    port_value_true,
  input  wire [2:0]    port_value_comp,
  input  wire [2:0]    compare_pin_direction,
  input  wire [2:0]    comp_pin_direction,
  output reg  [CW-1:0] compare_value_c,
  output reg  [2:0]    irq_request,
  output reg  [2:0]    pin_true_o,
  output reg  [2:0]    pin_true_oe,
  output reg  [2:0]    pin_comp_o,
  output reg  [2:0]    pin_comp_oe
);
  // Unit index 0..2 is A, B, D; compare arrays index 0..3 is A, B, C, D
  reg [7:0]    ctrl_r;
  reg [5:0]    action_r;
  reg [2:0]    match_flag_r;
  reg [2:0]    irq_en_r;
  reg [7:0]    dead_time_values_r;
  reg [CW-1:0] cmp_act_r [0:3];
  reg [CW-1:0] cmp_buf_r [0:3];
  reg [2:0]    hit_q_r;
  reg          block_r;
  reg [2:0]    force_r;
  reg [2:0]    raw_waveform_output_r;
  reg [2:0]    wave_prev_r;
  reg [3:0]    dt_cnt_r [0:2];
  reg [2:0]    compare_output_true_r;
  reg [2:0]    compare_output_comp_r;
  reg [2:0]    pre_cnt_r;
  reg [7:0]    aw_addr_r;
  reg [31:0]   w_data_r;
  reg [3:0]    w_strb_r;
  reg          aw_got_r;
  reg          w_got_r;
  wire [1:0] waveform_mode_select = ctrl_r[`CDOU_CTRL_WMS_HI:`CDOU_CTRL_WMS_LO];
  wire [1:0] nonoverlap_prescale_select = ctrl_r[`CDOU_CTRL_DTPS_HI:`CDOU_CTRL_DTPS_LO];
  wire [3:0] rise_delay_count = dead_time_values_r[`CDOU_DT_RISE_HI:`CDOU_DT_RISE_LO];
  wire [3:0] fall_delay_count = dead_time_values_r[`CDOU_DT_FALL_HI:`CDOU_DT_FALL_LO];
  wire       pair_inversion_enable = ctrl_r[`CDOU_CTRL_INV];
  wire [2:0] pulse_mode_enable = {ctrl_r[`CDOU_CTRL_PWM_D], ctrl_r[`CDOU_CTRL_PWM_B],
                                  ctrl_r[`CDOU_CTRL_PWM_A]};
  wire       pwm_any = |pulse_mode_enable;
  wire       fast_mode = (waveform_mode_select == `CDOU_WMS_FAST);
  // Transfer point of the buffered compare values: top for single slope, bottom for dual
  wire xfer = timer_tick & pwm_any & (fast_mode ? count_at_top : count_at_bottom);
  // Write strobe and decode of the pending bus write
  wire do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
  // Byte-lane merge into a compare word; lanes above the compare width are dropped
  function [CW-1:0] lane_merge;
    input [CW-1:0] old_v;
    input [31:0]   new_v;
    input [3:0]    strb;
    integer k;
    reg [31:0] t;
    begin
      t = {{(32-CW){1'b0}}, old_v};
      for (k = 0; k < 4; k = k + 1) begin
        t[k*8 +: 8] = strb[k] ? new_v[k*8 +: 8] : t[k*8 +: 8];
      end
      lane_merge = t[CW-1:0];
    end
  endfunction
  // Address decode shared by the read and write paths
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CDOU_OFF_CTRL) | (a == `CDOU_OFF_ACTION) | (a == `CDOU_OFF_FLAGS) |
               (a == `CDOU_OFF_IRQ_EN) | (a == `CDOU_OFF_FORCE) |
               (a == `CDOU_OFF_DEADTIME) | (a == `CDOU_OFF_CMP_A) |
               (a == `CDOU_OFF_CMP_B) | (a == `CDOU_OFF_CMP_C) | (a == `CDOU_OFF_CMP_D);
    end
  endfunction
  // Next waveform level for one unit given a match or forced match
  function wave_next;
    input       cur;
    input       pwm;
    input [1:0] act;
    input       hit;
    input       wrap;
    input       fast;
    input       down;
    begin
      wave_next = cur;
      if (!pwm) begin
        if (hit) begin
          case (act)
            `CDOU_ACT_COMP:  wave_next = ~cur;
            `CDOU_ACT_CLEAR: wave_next = 1'b0;
            `CDOU_ACT_SET:   wave_next = 1'b1;
            default:         wave_next = cur;
          endcase
        end
      end else if (act != `CDOU_ACT_NONE) begin
        // Fast PWM: 2 and 1 clear on match, 3 sets; the opposite at wrap
        if (fast && wrap) begin
          wave_next = (act != `CDOU_ACT_SET);
        end
        if (hit) begin
          wave_next = (act == `CDOU_ACT_SET) ^ (~fast & down);
        end
      end
    end
  endfunction
  // Match pulses of units A, B, D in this tick; a counter write blocks them
  wire [2:0] hit_now;
  assign hit_now[0] = timer_tick & ~block_r & (timer_count_value == cmp_act_r[0]);
  assign hit_now[1] = timer_tick & ~block_r & (timer_count_value == cmp_act_r[1]);
  assign hit_now[2] = timer_tick & ~block_r & (timer_count_value == cmp_act_r[3]);
  // Dead time clock enable: every 1, 2, 4 or 8 timer ticks
  wire [2:0] pre_mask = (3'h1 << nonoverlap_prescale_select) - 3'h1;
  wire       dt_en = timer_tick & ((pre_cnt_r & pre_mask) == 3'h0);
  // Units in complementary dead time mode
  wire [2:0] pair_mode;
  assign pair_mode[0] = pulse_mode_enable[0] & (action_r[1:0] == `CDOU_ACT_COMP);
  assign pair_mode[1] = pulse_mode_enable[1] & (action_r[3:2] == `CDOU_ACT_COMP);
  assign pair_mode[2] = pulse_mode_enable[2] & (action_r[5:4] == `CDOU_ACT_COMP);
  integer i;
  // AXI4-Lite write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CDOU_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? `CDOU_RESP_OKAY : `CDOU_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel: one read at a time, answer one cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CDOU_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? `CDOU_RESP_OKAY : `CDOU_RESP_SLVERR;
        case (s_axi_araddr)
          `CDOU_OFF_CTRL:     s_axi_rdata <= {24'h000000, ctrl_r};
          `CDOU_OFF_ACTION:   s_axi_rdata <= {26'h0000000, action_r};
          `CDOU_OFF_FLAGS:    s_axi_rdata <= {29'h00000000, match_flag_r};
          `CDOU_OFF_IRQ_EN:   s_axi_rdata <= {29'h00000000, irq_en_r};
          `CDOU_OFF_DEADTIME: s_axi_rdata <= {24'h000000, dead_time_values_r};
          // Buffered copy always holds the latest write
          `CDOU_OFF_CMP_A:    s_axi_rdata <= {{(32-CW){1'b0}}, cmp_buf_r[0]};
          `CDOU_OFF_CMP_B:    s_axi_rdata <= {{(32-CW){1'b0}}, cmp_buf_r[1]};
          `CDOU_OFF_CMP_C:    s_axi_rdata <= {{(32-CW){1'b0}}, cmp_buf_r[2]};
          `CDOU_OFF_CMP_D:    s_axi_rdata <= {{(32-CW){1'b0}}, cmp_buf_r[3]};
          default:            s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software registers; action bits take effect at once, with no buffering
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r             <= `CDOU_RST_CTRL;
      action_r           <= `CDOU_RST_ACTION;
      irq_en_r           <= 3'h0;
      dead_time_values_r <= `CDOU_RST_DT;
      force_r            <= 3'h0;
    end else begin
      force_r <= 3'h0;
      if (do_write && w_strb_r[0]) begin
        case (aw_addr_r)
          `CDOU_OFF_CTRL:     ctrl_r <= w_data_r[7:0];
          `CDOU_OFF_ACTION:   action_r <= w_data_r[5:0];
          `CDOU_OFF_IRQ_EN:   irq_en_r <= w_data_r[2:0];
          `CDOU_OFF_DEADTIME: dead_time_values_r <= w_data_r[7:0];
          `CDOU_OFF_FORCE:    force_r <= w_data_r[2:0] & ~pulse_mode_enable;
          default:            ctrl_r <= ctrl_r;
        endcase
      end
    end
  end

  // Compare registers: direct in normal mode, through the buffer in PWM modes
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        cmp_act_r[i] <= `CDOU_RST_CMP;
        cmp_buf_r[i] <= `CDOU_RST_CMP;
      end
      compare_value_c <= `CDOU_RST_CMP;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (xfer) begin
          cmp_act_r[i] <= cmp_buf_r[i];
        end
        if (do_write && (aw_addr_r == (`CDOU_OFF_CMP_A + 8'h04 * i[7:0]))) begin
          cmp_buf_r[i] <= lane_merge(cmp_buf_r[i], w_data_r, w_strb_r);
          if (!pwm_any) begin
            cmp_act_r[i] <= lane_merge(cmp_act_r[i], w_data_r, w_strb_r);
          end
        end
      end
      compare_value_c <= cmp_act_r[2];
    end
  end
  // Match flags: set one tick after the match; set wins over any clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      hit_q_r      <= 3'h0;
      match_flag_r <= 3'h0;
      block_r      <= 1'b0;
      irq_request  <= 3'h0;
    end else begin
      if (count_write) begin
        block_r <= 1'b1;
      end else if (timer_tick) begin
        block_r <= 1'b0;
      end
      if (timer_tick) begin
        hit_q_r <= hit_now;
      end
      for (i = 0; i < 3; i = i + 1) begin
        if (timer_tick && hit_q_r[i]) begin
          match_flag_r[i] <= 1'b1;
        end else if (irq_service[i] ||
                     (do_write && w_strb_r[0] && aw_addr_r == `CDOU_OFF_FLAGS &&
                      w_data_r[i])) begin
          match_flag_r[i] <= 1'b0;
        end
      end
      irq_request <= match_flag_r & irq_en_r;
    end
  end

  // Waveform generators; state survives mode changes, only reset clears it
  always @(posedge aclk) begin
    if (!aresetn) begin
      raw_waveform_output_r <= 3'h0;
    end else begin
      raw_waveform_output_r[0] <= wave_next(raw_waveform_output_r[0], pulse_mode_enable[0],
                                 action_r[1:0], hit_now[0] | force_r[0],
                                 timer_tick & count_at_top, fast_mode, count_down);
      raw_waveform_output_r[1] <= wave_next(raw_waveform_output_r[1], pulse_mode_enable[1],
                                 action_r[3:2], hit_now[1] | force_r[1],
                                 timer_tick & count_at_top, fast_mode, count_down);
      raw_waveform_output_r[2] <= wave_next(raw_waveform_output_r[2], pulse_mode_enable[2],
                                 action_r[5:4], hit_now[2] | force_r[2],
                                 timer_tick & count_at_top, fast_mode, count_down);
    end
  end

  // Dead time prescaler counts timer ticks
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= 3'h0;
    end else if (timer_tick) begin
      pre_cnt_r <= pre_cnt_r + 3'h1;
    end
  end

  // Dead time generators: both outputs drop on an edge, the rising one waits for zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      wave_prev_r           <= 3'h0;
      compare_output_true_r <= 3'h0;
      compare_output_comp_r <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        dt_cnt_r[i] <= 4'h0;
      end
    end else if (timer_tick) begin
      for (i = 0; i < 3; i = i + 1) begin
        wave_prev_r[i] <= raw_waveform_output_r[i];
        if (!pair_mode[i]) begin
          // Plain synchroniser stage, one tick behind the waveform
          dt_cnt_r[i]              <= 4'h0;
          compare_output_true_r[i] <= raw_waveform_output_r[i];
          compare_output_comp_r[i] <= ~raw_waveform_output_r[i];
        end else if (raw_waveform_output_r[i] != wave_prev_r[i]) begin
          dt_cnt_r[i] <= raw_waveform_output_r[i] ? rise_delay_count
                                                  : fall_delay_count;
          compare_output_true_r[i] <= 1'b0;
          compare_output_comp_r[i] <= 1'b0;
        end else if (dt_cnt_r[i] != 4'h0) begin
          if (dt_en) begin
            dt_cnt_r[i] <= dt_cnt_r[i] - 4'h1;
          end
        end else begin
          compare_output_true_r[i] <= raw_waveform_output_r[i];
          compare_output_comp_r[i] <= ~raw_waveform_output_r[i];
        end
      end
    end
  end

  // Pin stage: override the true port value when the unit's action is active, the comp value in pair mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_true_o  <= 3'h0;
      pin_comp_o  <= 3'h0;
      pin_true_oe <= 3'h0;
      pin_comp_oe <= 3'h0;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        // Direction stays with the port; the value only shows when driven
        pin_true_oe[i] <= compare_pin_direction[i];
        pin_comp_oe[i] <= comp_pin_direction[i];
        pin_true_o[i] <= (action_r[2*i +: 2] != `CDOU_ACT_NONE) ?
                         (compare_output_true_r[i] ^ (pair_mode[i] & pair_inversion_enable)) :
                         port_value_true[i];
        pin_comp_o[i] <= pair_mode[i] ? (compare_output_comp_r[i] ^ pair_inversion_enable) :
                         port_value_comp[i];
      end
    end
  end
endmodule

// ===== testbench/cdou_monitor.sv
// Checker for bus handshakes and pin outputs of the compare unit
module cdou_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  compare_pin_direction,
  input wire logic [2:0]  comp_pin_direction,
  input wire logic [2:0]  pin_true_o,
  input wire logic [2:0]  pin_true_oe,
  input wire logic [2:0]  pin_comp_o,
  input wire logic [2:0]  pin_comp_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  // Both write channels taken in one cycle, and a read request taken
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (disable iff (!aresetn) s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response missing two cycles after take");
  a_bresp_hold: assert property (disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_read_answer: assert property (disable iff (!aresetn) s_rd_take |=> s_axi_rvalid)
    else $error("read data missing one cycle after take");
  a_rdata_hold: assert property (disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_write_busy: assert property (disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_read_busy: assert property (disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");
  a_err_zero: assert property (disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned nonzero data");
  // Reset must not be a disable here, it is the cause
  a_reset_pins: assert property (!aresetn |=> pin_true_o == 3'h0 && pin_comp_o == 3'h0
    && pin_true_oe == 3'h0 && pin_comp_oe == 3'h0)
    else $error("pins not cleared by reset");
  a_dir_drives_oe: assert property (disable iff (!aresetn) $past(aresetn) |->
    pin_true_oe == $past(compare_pin_direction) && pin_comp_oe == $past(comp_pin_direction))
    else $error("pin enable does not follow direction bits");
endmodule
bind cdou_top cdou_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .compare_pin_direction(compare_pin_direction), .comp_pin_direction(comp_pin_direction),
  .pin_true_o(pin_true_o), .pin_true_oe(pin_true_oe), .pin_comp_o(pin_comp_o),
  .pin_comp_oe(pin_comp_oe));

// ===== testbench/cdou_switch_model.sv
// Gate drivers of the external power switches, one high and one low side per pair
module cdou_switch_model (
  input wire logic [2:0]  pin_true_o,
  input wire logic [2:0]  pin_true_oe,
  input wire logic [2:0]  pin_comp_o,
  input wire logic [2:0]  pin_comp_oe,
  output wire logic [2:0] hi_on,
  output wire logic [2:0] lo_on
);
  // A released pad is pulled low by the driver, so the switch stays off
  assign hi_on = pin_true_o & pin_true_oe;
  assign lo_on = pin_comp_o & pin_comp_oe;
endmodule

// ===== testbench/cdou_tb_top.sv
// Self-checking bench for the compare, dead time and pin unit
`include "cdou_regs.vh"
module cdou_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        tick = 1'b0, cw = 1'b0, run = 1'b0;
  logic [9:0]  cnt = 10'h000, top = 10'h014;
  logic [2:0]  svc = 3'h0, pv = 3'h0, dir = 3'h0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [2:0]   irq, pto, ptoe, pco, pcoe, hi_on, lo_on;
  wire [9:0]   cvc;
  int          n_fail = 0, total_checks = 0, cyc = 0, b_on, b_off, gap;
  logic [31:0] rd;
  logic [1:0]  rs;
  // Register rows: address, value read after all-ones write, response
  logic [7:0]  ra [6] = '{`CDOU_OFF_CTRL, `CDOU_OFF_ACTION, `CDOU_OFF_DEADTIME,
                          `CDOU_OFF_CMP_A, `CDOU_OFF_FORCE, 8'h28};
  logic [31:0] rm [6] = '{32'hff, 32'h3f, 32'hff, 32'h3ff, 32'h0, 32'h0};
  logic [1:0]  re [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  // Action rows for forced matches: code and resulting waveform
  logic [1:0]  fa [4] = '{`CDOU_ACT_SET, `CDOU_ACT_CLEAR, `CDOU_ACT_COMP, `CDOU_ACT_COMP};
  logic        fe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  cdou_top #(.CW(10)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_tick(tick),
    .timer_count_value(cnt), .count_at_top(cnt == top), .count_at_bottom(cnt == 10'h000),
    .count_down(1'b0), .count_write(cw), .irq_service(svc), .port_value_true(pv),
    .port_value_comp(pv), .compare_pin_direction(dir), .comp_pin_direction(dir),
    .compare_value_c(cvc), .irq_request(irq), .pin_true_o(pto), .pin_true_oe(ptoe),
    .pin_comp_o(pco), .pin_comp_oe(pcoe));
  cdou_switch_model u_sw (.pin_true_o(pto), .pin_true_oe(ptoe), .pin_comp_o(pco),
    .pin_comp_oe(pcoe), .hi_on(hi_on), .lo_on(lo_on));

  always #12.5 aclk = ~aclk;
  // Counter stands in for the timer core; ceiling cuts a hang short
  always @(posedge aclk) begin
    if (run) cnt <= (cnt == top) ? 10'h000 : cnt + 10'h001;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Ticks at v and v+1, the second one lands a flag; with blk the write precedes them
  task automatic put_cnt(input logic [9:0] v, input logic blk);
    @(posedge aclk);
    cnt <= v;
    cw <= blk;
    @(posedge aclk);
    cw <= 1'b0;
    tick <= 1'b1;
    @(posedge aclk);
    cnt <= v + 10'h001;
    @(posedge aclk);
    tick <= 1'b0;
  endtask
  // Counts overlap and gap cycles of pair A at the switches
  task automatic sample();
    int g;
    b_on = 0;
    b_off = 0;
    gap = 0;
    g = 0;
    repeat (64) begin
      @(posedge aclk);
      if (hi_on[0] && lo_on[0]) b_on++;
      g = (!hi_on[0] && !lo_on[0]) ? g + 1 : 0;
      if (g > 0) b_off++;
      if (g > gap) gap = g;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    chk("oe_in_reset", 32'h0, {26'h0, ptoe, pcoe});
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rdr(ra[i]);
      chk("reset_value", 32'h0, rd);
      chk("reset_resp", {30'h0, re[i]}, {30'h0, rs});
      wr(ra[i], 32'hffffffff);
      chk("write_resp", {30'h0, re[i]}, {30'h0, rs});
      rdr(ra[i]);
      chk("readback", rm[i], rd);
    end
    for (int i = 0; i < 4; i++) wr(ra[i], 32'h0);
    // Count parked off every compare, so only the strobe moves the waveform
    cnt <= 10'h3ff;
    tick <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`CDOU_OFF_ACTION, {30'h0, fa[i]});
      wr(`CDOU_OFF_FORCE, 32'h1);
      repeat (8) @(posedge aclk);
      chk("forced_pin", {31'h0, fe[i]}, {31'h0, pto[0]});
    end
    dir <= 3'h1;
    wr(`CDOU_OFF_ACTION, 32'h0);
    pv <= 3'h1;
    repeat (4) @(posedge aclk);
    chk("pin_enable", 32'h1, {31'h0, ptoe[0]});
    chk("port_value", 32'h1, {31'h0, pto[0]});
    pv <= 3'h0;
    tick <= 1'b0;
    wr(`CDOU_OFF_CMP_A, 32'h5);
    wr(`CDOU_OFF_IRQ_EN, 32'h1);
    put_cnt(10'h005, 1'b0);
    repeat (4) @(posedge aclk);
    chk("irq_set", 32'h1, {31'h0, irq[0]});
    rdr(`CDOU_OFF_FLAGS);
    chk("flag_set", 32'h1, rd);
    wr(`CDOU_OFF_FLAGS, 32'h0);
    rdr(`CDOU_OFF_FLAGS);
    chk("flag_kept", 32'h1, rd);
    wr(`CDOU_OFF_FLAGS, 32'h1);
    rdr(`CDOU_OFF_FLAGS);
    chk("flag_w1c", 32'h0, rd);
    put_cnt(10'h005, 1'b0);
    repeat (3) @(posedge aclk);
    chk("irq_again", 32'h1, {31'h0, irq[0]});
    svc <= 3'h1;
    @(posedge aclk);
    svc <= 3'h0;
    repeat (3) @(posedge aclk);
    chk("irq_serviced", 32'h0, {31'h0, irq[0]});
    put_cnt(10'h005, 1'b1);
    rdr(`CDOU_OFF_FLAGS);
    chk("blocked_match", 32'h0, rd);
    wr(`CDOU_OFF_ACTION, 32'h1);
    put_cnt(10'h005, 1'b0);
    @(posedge aclk);
    tick <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("toggle_match", 32'h1, {31'h0, pto[0]});
    // Complementary pair in fast mode, rise delay 3, fall delay 2
    wr(`CDOU_OFF_CMP_A, 32'h8);
    wr(`CDOU_OFF_CMP_C, 32'hf);
    top <= 10'h00f;
    wr(`CDOU_OFF_DEADTIME, 32'h32);
    chk("cmp_c_direct", 32'hf, {22'h0, cvc});
    wr(`CDOU_OFF_CTRL, 32'h4);
    cnt <= 10'h000;
    run <= 1'b1;
    repeat (40) @(posedge aclk);
    sample();
    chk("overlap", 32'h0, b_on);
    chk("gap_seen", 32'h1, {31'h0, b_off > 0});
    chk("rise_gap", 32'h1, {31'h0, gap >= 3});
    wr(`CDOU_OFF_CMP_A, 32'h9);
    rdr(`CDOU_OFF_CMP_A);
    chk("buffered_read", 32'h9, rd);
    wr(`CDOU_OFF_CTRL, 32'h24);
    repeat (40) @(posedge aclk);
    sample();
    chk("inv_low_gap", 32'h0, b_off);
    chk("inv_high_gap", 32'h1, {31'h0, b_on > 0});
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("pins_reset", 32'h0, {26'h0, pto, pco});
    aresetn <= 1'b1;
    run <= 1'b0;
    wrap_up();
  end
endmodule
